// [logic/capture_input_cond.sv]
/*
 * Input conditioning for one capture channel: digital filter with a
 * selectable sampling divider and run length, rising edge detection and
 * an event divider that emits one capture pulse every 1, 2, 4 or 8 edges.
 * Assumes sample_in is already synchronous to sys_clk.
 */
`timescale 1ns/100ps
module capture_input_cond (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic                 ce,
   // Configuration
   input  wire ccmode_pkg::in_cfg_t  cfg,
   input  wire logic                 capture_enable,
   // Signal
   input  wire logic                 sample_in,
   output logic                      filtered_level,
   output logic                      capture_pulse
);

   logic [4:0] div_cnt_ff,   nxt_div_cnt;
   logic [3:0] run_cnt_ff,   nxt_run_cnt;
   logic       level_ff,     nxt_level;
   logic       level_d_ff,   nxt_level_d;
   logic [2:0] psc_cnt_ff,   nxt_psc_cnt;
   logic       pulse_ff,     nxt_pulse;
   logic [4:0] div_max;
   logic [3:0] run_len;
   logic [2:0] psc_max;

   // Table lookup; code zero means run length one at full rate
   assign div_max = 5'((6'h01 << ccmode_pkg::FLT_DIV_LOG2[cfg.filter])
                       - 6'h01);
   assign run_len = ccmode_pkg::FLT_LEN[cfg.filter];
   assign psc_max = 3'((4'h1 << cfg.divider) - 4'h1);

   // Filter: new level only after run_len equal samples in a row
   always_comb begin
      nxt_div_cnt = div_cnt_ff;
      nxt_run_cnt = run_cnt_ff;
      nxt_level   = level_ff;
      if (div_cnt_ff >= div_max) begin
         nxt_div_cnt = 5'h00;
         if (sample_in == level_ff) begin
            nxt_run_cnt = 4'h0;
         end else if (run_cnt_ff + 4'h1 >= run_len) begin
            nxt_run_cnt = 4'h0;
            nxt_level   = sample_in;
         end else begin
            nxt_run_cnt = run_cnt_ff + 4'h1;
         end
      end else begin
         nxt_div_cnt = div_cnt_ff + 5'h01;
      end
   end

   // Edge detection and event division
   always_comb begin
      nxt_level_d = level_ff;
      nxt_psc_cnt = psc_cnt_ff;
      nxt_pulse   = 1'b0;
      if (!capture_enable) begin
         // Restart the division so a re-enable starts a clean count
         nxt_psc_cnt = 3'h0;
      end else if (level_ff && !level_d_ff) begin
         if (psc_cnt_ff >= psc_max) begin
            nxt_psc_cnt = 3'h0;
            nxt_pulse   = 1'b1;
         end else begin
            nxt_psc_cnt = psc_cnt_ff + 3'h1;
         end
      end
   end

   // Registers, frozen while ce is low
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         div_cnt_ff <= 5'h00;
         run_cnt_ff <= 4'h0;
         level_ff   <= 1'b0;
         level_d_ff <= 1'b0;
         psc_cnt_ff <= 3'h0;
         pulse_ff   <= 1'b0;
      end else if (ce) begin
         div_cnt_ff <= nxt_div_cnt;
         run_cnt_ff <= nxt_run_cnt;
         level_ff   <= nxt_level;
         level_d_ff <= nxt_level_d;
         psc_cnt_ff <= nxt_psc_cnt;
         pulse_ff   <= nxt_pulse;
      end
   end

   assign filtered_level = level_ff;
   assign capture_pulse  = pulse_ff;

endmodule

// [logic/ccmode_ch3_ch4_config.sv]
/*
 * Mode configuration for channels 3 and 4 of a capture/compare unit:
 * the 16-bit mode register, a channel enable register, a status view,
 * input source selection, capture conditioning and the output reference
 * clear and fast paths. Assumes a classic Wishbone master on sys_clk and
 * compare references computed by counter logic outside this block.
 */
// Decided for this implementation: the Wishbone register port and the register addresses.
// Summary of operation
// - Channel 3 selector bits change only while channel 3 is disabled.
// - Channel 4 selector 00 is output, 01 input four, 10 input three, 11 internal trigger only in trigger mode.
// - Channel 4 selector bits change only while channel 4 is disabled.
// - Channel 3 fast enable lets a trigger event reach its reference one stage early.
// - Channel 3 clear enable lets a high filtered external trigger force its reference low.
// - Channel 3 preload sits at bit 3 and its compare mode at bits 6 to 4.
// - Channel 4 fast at bit 10, buffer enable at 11, mode at 14 to 12, clear at 15.
// - Channel 3 capture fires once every 1, 2, 4 or 8 input edges per bits 3 to 2.
// - Input mode holds filter 3 at 7 to 4, divider 4 at 11 to 10, filter 4 at 15 to 12.
// - Filter code picks sampling divider and run length; zero is no filtering.
`timescale 1ns/100ps
module ccmode_ch3_ch4_config (
   // Clock and reset
   input  wire logic                            sys_clk,
   input  wire logic                            rstn,
   input  wire logic                            ce,
   // Wishbone slave
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [ccmode_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [ccmode_pkg::SEL_W-1:0]    wb_sel_i,
   input  wire logic [ccmode_pkg::DAT_W-1:0]    wb_dat_i,
   output logic      [ccmode_pkg::DAT_W-1:0]    wb_dat_o,
   output logic                                 wb_ack_o,
   // Timer inputs
   input  wire logic                            timer_input_three,
   input  wire logic                            timer_input_four,
   input  wire logic                            internal_trigger_source,
   input  wire logic                            internal_trigger_mode,
   input  wire logic                            filtered_external_trigger,
   input  wire logic                            trigger_event,
   // Raw compare references from the counter logic
   input  wire logic                            ch3_raw_reference,
   input  wire logic                            ch4_raw_reference,
   // Channel outputs
   output logic                                 ch3_output_reference,
   output logic                                 ch4_output_reference,
   output logic                                 ch3_capture_event,
   output logic                                 ch4_capture_event,
   // Configuration views for the counter logic
   output ccmode_pkg::out_cfg_t                 ch3_out_cfg,
   output ccmode_pkg::out_cfg_t                 ch4_out_cfg,
   output logic                                 ch3_is_input,
   output logic                                 ch4_is_input
);

   localparam int NCH = 2;

   logic [15:0]               mode_ff,   nxt_mode;
   logic [15:0]               enable_ff, nxt_enable;
   logic                      ack_ff,    nxt_ack;
   logic [ccmode_pkg::DAT_W-1:0] dat_ff, nxt_dat;
   logic [NCH-1:0]            raw_d_ff,  nxt_raw_d;
   logic [NCH-1:0]            ref_ff,    nxt_ref;
   logic [7:0]                cnt3_ff,   nxt_cnt3;
   logic [7:0]                cnt4_ff,   nxt_cnt4;

   ccmode_pkg::out_cfg_t      ocfg [NCH];
   ccmode_pkg::in_cfg_t       icfg [NCH];
   logic [NCH-1:0]            chan_en;
   logic [NCH-1:0]            raw_ref;
   logic [NCH-1:0]            src;
   logic [NCH-1:0]            level;
   logic [NCH-1:0]            cap;
   logic                      req;
   logic                      wr_take;
   logic [ccmode_pkg::DAT_W-1:0] status;

   // Byte views of the two channel configurations
   assign ocfg[0] = ccmode_pkg::out_cfg_t'(mode_ff[7:0]);
   assign ocfg[1] = ccmode_pkg::out_cfg_t'(
                       mode_ff[ccmode_pkg::CH4_BYTE_LSB +:
                               ccmode_pkg::CH_BYTE_W]);
   assign icfg[0] = ccmode_pkg::in_cfg_t'(mode_ff[7:0]);
   assign icfg[1] = ccmode_pkg::in_cfg_t'(
                       mode_ff[ccmode_pkg::CH4_BYTE_LSB +:
                               ccmode_pkg::CH_BYTE_W]);
   assign chan_en = {enable_ff[ccmode_pkg::CH4_EN_POS],
                     enable_ff[ccmode_pkg::CH3_EN_POS]};
   assign raw_ref = {ch4_raw_reference, ch3_raw_reference};

   // Input source selection; trigger source is dead outside trigger mode
   always_comb begin
      src = '0;
      unique case (ocfg[0].dir)
         ccmode_pkg::DIR_OUTPUT:   src[0] = 1'b0;
         ccmode_pkg::DIR_IN_OWN:   src[0] = timer_input_three;
         ccmode_pkg::DIR_IN_OTHER: src[0] = timer_input_four;
         ccmode_pkg::DIR_IN_TRIG:  src[0] = internal_trigger_source &
                                            internal_trigger_mode;
      endcase
      unique case (ocfg[1].dir)
         ccmode_pkg::DIR_OUTPUT:   src[1] = 1'b0;
         ccmode_pkg::DIR_IN_OWN:   src[1] = timer_input_four;
         ccmode_pkg::DIR_IN_OTHER: src[1] = timer_input_three;
         ccmode_pkg::DIR_IN_TRIG:  src[1] = internal_trigger_source &
                                            internal_trigger_mode;
      endcase
   end

   // One conditioner per channel; capture only while input and enabled
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_cond
         capture_input_cond u_cond (
            .sys_clk        (sys_clk),
            .rstn           (rstn),
            .ce             (ce),
            .cfg            (icfg[g]),
            .capture_enable (chan_en[g] &&
                             icfg[g].dir != ccmode_pkg::DIR_OUTPUT),
            .sample_in      (src[g]),
            .filtered_level (level[g]),
            .capture_pulse  (cap[g])
         );
      end
   endgenerate

   // Bus decode; the write lands on the edge that sees ack high
   assign req     = wb_cyc_i && wb_stb_i;
   assign wr_take = req && wb_we_i && ack_ff;

   // Status word shows live block state
   always_comb begin
      status = '0;
      status[ccmode_pkg::ST_LVL3_POS] = level[0];
      status[ccmode_pkg::ST_LVL4_POS] = level[1];
      status[ccmode_pkg::ST_REF3_POS] = ref_ff[0];
      status[ccmode_pkg::ST_REF4_POS] = ref_ff[1];
      status[ccmode_pkg::ST_CNT3_LSB +: 8] = cnt3_ff;
      status[ccmode_pkg::ST_CNT4_LSB +: 8] = cnt4_ff;
   end

   // Register file next state and read mux
   always_comb begin
      nxt_mode   = mode_ff;
      nxt_enable = enable_ff;
      nxt_ack    = req && !ack_ff;
      nxt_dat    = dat_ff;
      if (wr_take && wb_adr_i == ccmode_pkg::MODE_OFS) begin
         if (wb_sel_i[0]) begin
            nxt_mode[7:0] = wb_dat_i[7:0];
            // Direction held while the channel runs
            if (chan_en[0]) begin
               nxt_mode[ccmode_pkg::SEL_LSB +: ccmode_pkg::SEL_W_BITS] =
                  mode_ff[ccmode_pkg::SEL_LSB +:
                          ccmode_pkg::SEL_W_BITS];
            end
         end
         if (wb_sel_i[1]) begin
            nxt_mode[15:8] = wb_dat_i[15:8];
            if (chan_en[1]) begin
               nxt_mode[ccmode_pkg::CH4_BYTE_LSB +:
                        ccmode_pkg::SEL_W_BITS] =
                  mode_ff[ccmode_pkg::CH4_BYTE_LSB +:
                          ccmode_pkg::SEL_W_BITS];
            end
         end
      end
      if (wr_take && wb_adr_i == ccmode_pkg::ENABLE_OFS && wb_sel_i[1]) begin
         nxt_enable[ccmode_pkg::CH3_EN_POS] =
            wb_dat_i[ccmode_pkg::CH3_EN_POS];
         nxt_enable[ccmode_pkg::CH4_EN_POS] =
            wb_dat_i[ccmode_pkg::CH4_EN_POS];
      end
      // Read data captured with the ack so it is stable while ack is high
      if (req && !ack_ff) begin
         if (wb_adr_i == ccmode_pkg::MODE_OFS) begin
            nxt_dat = {16'h0000, mode_ff};
         end else if (wb_adr_i == ccmode_pkg::ENABLE_OFS) begin
            nxt_dat = {16'h0000, enable_ff};
         end else if (wb_adr_i == ccmode_pkg::STATUS_OFS) begin
            nxt_dat = status;
         end else begin
            nxt_dat = '0; // Unmapped: acked, reads zero
         end
      end
   end

   // Register file storage
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mode_ff   <= ccmode_pkg::MODE_RST;
         enable_ff <= ccmode_pkg::ENABLE_RST;
         ack_ff    <= 1'b0;
         dat_ff    <= '0;
      end else if (ce) begin
         mode_ff   <= nxt_mode;
         enable_ff <= nxt_enable;
         ack_ff    <= nxt_ack;
         dat_ff    <= nxt_dat;
      end
   end

   // Output reference: clear beats fast, fast bypasses one stage
   always_comb begin
      nxt_raw_d = raw_ref;
      nxt_ref   = '0;
      for (int i = 0; i < NCH; i++) begin
         if (ocfg[i].dir != ccmode_pkg::DIR_OUTPUT) begin
            nxt_ref[i] = 1'b0; // Reference idles low in input mode
         end else if (ocfg[i].clear_en && filtered_external_trigger) begin
            nxt_ref[i] = 1'b0;
         end else if (ocfg[i].fast && trigger_event) begin
            nxt_ref[i] = raw_ref[i];
         end else begin
            nxt_ref[i] = raw_d_ff[i];
         end
      end
   end

   // Capture counters wrap; they only give software a sign of life
   always_comb begin
      nxt_cnt3 = cap[0] ? cnt3_ff + 8'h01 : cnt3_ff;
      nxt_cnt4 = cap[1] ? cnt4_ff + 8'h01 : cnt4_ff;
   end

   // Reference pipeline and counters
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         raw_d_ff <= '0;
         ref_ff   <= '0;
         cnt3_ff  <= ccmode_pkg::COUNT_RST;
         cnt4_ff  <= ccmode_pkg::COUNT_RST;
      end else if (ce) begin
         raw_d_ff <= nxt_raw_d;
         ref_ff   <= nxt_ref;
         cnt3_ff  <= nxt_cnt3;
         cnt4_ff  <= nxt_cnt4;
      end
   end

   // Outputs
   assign wb_dat_o             = dat_ff;
   assign wb_ack_o             = ack_ff;
   assign ch3_output_reference = ref_ff[0];
   assign ch4_output_reference = ref_ff[1];
   assign ch3_capture_event    = cap[0];
   assign ch4_capture_event    = cap[1];
   assign ch3_out_cfg          = ocfg[0];
   assign ch4_out_cfg          = ocfg[1];
   assign ch3_is_input         = ocfg[0].dir != ccmode_pkg::DIR_OUTPUT;
   assign ch4_is_input         = ocfg[1].dir != ccmode_pkg::DIR_OUTPUT;

endmodule

// [logic/ccmode_pkg.sv]
/*
 * Shared constants and types for the channel 3/4 mode configuration
 * block: register offsets, field positions, reset values, direction
 * codes, input filter tables and the packed channel configuration views.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package ccmode_pkg;

   // Register bus geometry
   localparam int          ADR_W        = 8;
   localparam int          DAT_W        = 32;
   localparam int          SEL_W        = 4;

   // Register offsets (byte addresses)
   localparam logic [7:0]  MODE_OFS     = 8'h1c;
   localparam logic [7:0]  ENABLE_OFS   = 8'h20;
   localparam logic [7:0]  STATUS_OFS   = 8'h3c;

   // Reset values
   localparam logic [15:0] MODE_RST     = 16'h0000;
   localparam logic [15:0] ENABLE_RST   = 16'h0000;
   localparam logic [7:0]  COUNT_RST    = 8'h00;

   // Layout: each channel owns one byte of the mode register
   localparam int          CH_BYTE_W    = 8;
   localparam int          CH4_BYTE_LSB = 8;
   localparam int          SEL_LSB      = 0;
   localparam int          SEL_W_BITS   = 2;
   localparam int          FAST_POS     = 2;
   localparam int          PRELOAD_POS  = 3;
   localparam int          MODE_LSB     = 4;
   localparam int          CLEAR_POS    = 7;
   localparam int          DIVIDER_LSB  = 2;
   localparam int          FILTER_LSB   = 4;

   // Channel enable bits in the enable register
   localparam int          CH3_EN_POS   = 8;
   localparam int          CH4_EN_POS   = 12;

   // Status register fields
   localparam int          ST_LVL3_POS  = 0;
   localparam int          ST_LVL4_POS  = 1;
   localparam int          ST_REF3_POS  = 2;
   localparam int          ST_REF4_POS  = 3;
   localparam int          ST_CNT3_LSB  = 8;
   localparam int          ST_CNT4_LSB  = 16;

   // Filter code tables: log2 of sampling divider and run length
   localparam logic [2:0]  FLT_DIV_LOG2 [16] = '{
      3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
      3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
   localparam logic [3:0]  FLT_LEN      [16] = '{
      4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
      4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};

   // Direction selector codes
   typedef enum logic [1:0] {
      DIR_OUTPUT   = 2'b00,
      DIR_IN_OWN   = 2'b01,
      DIR_IN_OTHER = 2'b10,
      DIR_IN_TRIG  = 2'b11
   } dir_t;

   // Channel byte seen as an output compare channel
   typedef struct packed {
      logic       clear_en;
      logic [2:0] compare_mode;
      logic       preload;
      logic       fast;
      dir_t       dir;
   } out_cfg_t;

   // Channel byte seen as an input capture channel
   typedef struct packed {
      logic [3:0] filter;
      logic [1:0] divider;
      dir_t       dir;
   } in_cfg_t;

endpackage

// [testbench/ccmode_assertions.sv]
/* Checker for the channel 3/4 mode block: bus handshake, selector lock,
   direction views and reference paths. Sees only the top module's ports
   and is bound to it from the testbench top file. */
`timescale 1ns/100ps
module ccmode_assertions (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rstn,
   input wire logic                 ce,
   // Register bus
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [7:0]           wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic                 wb_ack_o,
   // Channel side
   input wire logic                 filtered_external_trigger,
   input wire logic                 ch3_raw_reference,
   input wire logic                 ch3_output_reference,
   input wire logic                 ch3_capture_event,
   input wire ccmode_pkg::out_cfg_t ch3_out_cfg,
   input wire ccmode_pkg::out_cfg_t ch4_out_cfg,
   input wire logic                 ch3_is_input,
   input wire logic                 ch4_is_input
);
   logic en3_ff;
   logic en4_ff;
   logic nxt_en3;
   logic nxt_en4;
   logic en_wr;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // Shadow of the enable bits, taken from acked bus writes
   assign en_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
                  && wb_adr_i == ccmode_pkg::ENABLE_OFS && wb_sel_i[1];
   always_comb begin
      nxt_en3 = en_wr ? wb_dat_i[8] : en3_ff;
      nxt_en4 = en_wr ? wb_dat_i[12] : en4_ff;
   end
   always_ff @(posedge sys_clk) begin
      en3_ff <= rstn ? nxt_en3 : 1'b0;
      en4_ff <= rstn ? nxt_en4 : 1'b0;
   end

   // Reference held high three cycles with no clear in play
   sequence raw3_steady;
      (ce && !ch3_is_input && !ch3_out_cfg.clear_en && ch3_raw_reference)[*3];
   endsequence

   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_LATENCY: assert property
      (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_DIR3: assert property
      (ch3_is_input == (ch3_out_cfg.dir != ccmode_pkg::DIR_OUTPUT))
      else $error("ch3 direction view disagrees with selector");
   AST_DIR4: assert property
      (ch4_is_input == (ch4_out_cfg.dir != ccmode_pkg::DIR_OUTPUT))
      else $error("ch4 direction view disagrees with selector");
   AST_LOCK3: assert property (en3_ff |=> $stable(ch3_out_cfg.dir))
      else $error("ch3 selector changed while enabled");
   AST_LOCK4: assert property (en4_ff |=> $stable(ch4_out_cfg.dir))
      else $error("ch4 selector changed while enabled");
   AST_CLEAR3: assert property (ce && !ch3_is_input
      && ch3_out_cfg.clear_en && filtered_external_trigger
      |=> !ch3_output_reference)
      else $error("ch3 reference not cleared by external trigger");
   AST_REF3: assert property (raw3_steady |-> ch3_output_reference)
      else $error("ch3 reference did not follow raw reference");
   AST_INREF3: assert property
      (ce && ch3_is_input |=> !ch3_output_reference)
      else $error("ch3 reference not low in input mode");
   AST_CAP3: assert property (ch3_capture_event |=> !ch3_capture_event)
      else $error("ch3 capture event wider than one cycle");

   // Main scenarios reached
   cover property (ch3_capture_event);
   cover property (en3_ff && en_wr);
   cover property (ch3_out_cfg.clear_en && filtered_external_trigger);
endmodule

// [testbench/tb.sv]
/* Self-checking bench for the channel 3/4 mode block: register layout,
   selector lock, capture dividers, source routing and reference paths.
   Assumes the design package is compiled first and a 25 MHz clock. */
`timescale 1ns/100ps
module tb;
   logic                 sys_clk, rstn, ce, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0]           wb_adr_i;
   logic [3:0]           wb_sel_i;
   logic [31:0]          wb_dat_i, wb_dat_o;
   logic                 wb_ack_o, tin3, tin4, trg_src, trg_mode, ext;
   logic                 trig, raw3, raw4, ref3, ref4, cap3, cap4, in3, in4;
   ccmode_pkg::out_cfg_t cfg3, cfg4;
   int                   err_count, n_checks, cnt3, cnt4;

   ccmode_ch3_ch4_config u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .timer_input_three(tin3), .timer_input_four(tin4),
      .internal_trigger_source(trg_src), .internal_trigger_mode(trg_mode),
      .filtered_external_trigger(ext), .trigger_event(trig),
      .ch3_raw_reference(raw3), .ch4_raw_reference(raw4),
      .ch3_output_reference(ref3), .ch4_output_reference(ref4),
      .ch3_capture_event(cap3), .ch4_capture_event(cap4),
      .ch3_out_cfg(cfg3), .ch4_out_cfg(cfg4),
      .ch3_is_input(in3), .ch4_is_input(in4));

   // Free-running 40 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Capture pulses are tallied here, tasks look at the difference
   always @(posedge sys_clk) begin
      if (cap3 === 1'b1) cnt3++;
      if (cap4 === 1'b1) cnt4++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One classic cycle; waits for ack without assuming its latency
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      chk({31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      bus(1'b1, a, {16'h0000, d}, 4'h3, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, 4'hf, r);
      chk(r, e);
   endtask

   // Field placement, byte lanes, unmapped space
   task automatic t_layout();
      logic [31:0] r;
      rdc(ccmode_pkg::MODE_OFS, 32'h0);
      rdc(ccmode_pkg::ENABLE_OFS, 32'h0);
      wr(ccmode_pkg::MODE_OFS, 16'hd4b4);
      rdc(ccmode_pkg::MODE_OFS, 32'hd4b4);
      chk({26'h0, cfg3[7:2]}, 32'h2d);
      chk({26'h0, cfg4[7:2]}, 32'h35);
      bus(1'b1, ccmode_pkg::MODE_OFS, 32'hffff_ffff, 4'h1, r);
      rdc(ccmode_pkg::MODE_OFS, 32'hd4ff);
      bus(1'b1, 8'h04, 32'hffff_ffff, 4'hf, r);
      rdc(8'h04, 32'h0);
      wr(ccmode_pkg::MODE_OFS, 16'h0000);
   endtask

   // Selector writes refused while enabled, rest of byte still lands
   task automatic t_lock();
      wr(ccmode_pkg::MODE_OFS, 16'h0101);
      wr(ccmode_pkg::ENABLE_OFS, 16'h1100);
      wr(ccmode_pkg::MODE_OFS, 16'hf2f2);
      rdc(ccmode_pkg::MODE_OFS, 32'hf1f1);
      wr(ccmode_pkg::ENABLE_OFS, 16'h0000);
      wr(ccmode_pkg::MODE_OFS, 16'h0202);
      rdc(ccmode_pkg::MODE_OFS, 32'h0202);
      wr(ccmode_pkg::MODE_OFS, 16'h0000);
   endtask

   // Eight clean edges on one source, capture counts per channel
   task automatic t_cap(input logic ch4, input logic [1:0] sel,
                        input logic [1:0] dv, input logic src4,
                        input int e3, input int e4);
      int c3, c4;
      wr(ccmode_pkg::MODE_OFS, ch4 ? {4'h0, dv, sel, 8'h00}
                                   : {8'h00, 4'h0, dv, sel});
      wr(ccmode_pkg::ENABLE_OFS, ch4 ? 16'h1000 : 16'h0100);
      c3 = cnt3;
      c4 = cnt4;
      repeat (8) begin
         @(posedge sys_clk);
         if (src4) tin4 <= 1'b1; else tin3 <= 1'b1;
         repeat (2) @(posedge sys_clk);
         tin3 <= 1'b0;
         tin4 <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      chk(cnt3 - c3, e3);
      chk(cnt4 - c4, e4);
      wr(ccmode_pkg::ENABLE_OFS, 16'h0000);
      wr(ccmode_pkg::MODE_OFS, 16'h0000);
   endtask

   // Pulses of width w on input three and the trigger source together
   task automatic t_src(input logic [15:0] m, input logic tm, input int w,
                        input int e3, input int e4);
      int c3, c4;
      trg_mode <= tm;
      wr(ccmode_pkg::MODE_OFS, m);
      wr(ccmode_pkg::ENABLE_OFS, 16'h1100);
      c3 = cnt3;
      c4 = cnt4;
      repeat (4) begin
         @(posedge sys_clk);
         {tin3, trg_src} <= 2'b11;
         repeat (w) @(posedge sys_clk);
         {tin3, trg_src} <= 2'b00;
         repeat (4) @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      chk(cnt3 - c3, e3);
      chk(cnt4 - c4, e4);
      wr(ccmode_pkg::ENABLE_OFS, 16'h0000);
      wr(ccmode_pkg::MODE_OFS, 16'h0000);
   endtask

   // Raw reference rises with a trigger pulse; e1 is level one edge on
   task automatic t_ref(input logic [15:0] m, input logic e1);
      wr(ccmode_pkg::MODE_OFS, m);
      @(posedge sys_clk);
      raw3 <= 1'b0;
      repeat (3) @(posedge sys_clk);
      raw3 <= 1'b1;
      trig <= 1'b1;
      @(posedge sys_clk);
      trig <= 1'b0;
      #1;
      chk({31'h0, ref3}, {31'h0, e1});
      @(posedge sys_clk);
      #1;
      chk({31'h0, ref3}, 32'h1);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, far beyond the several hundred cycles the run needs
   initial begin
      #2_000_000;
      err_count++;
      end_of_test();
   end

   // Reset, then the scenarios in turn
   initial begin
      {rstn, wb_cyc_i, wb_stb_i, wb_we_i, tin3, tin4, trg_src} = 7'h00;
      {trg_mode, ext, trig, raw3, raw4} = 5'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      ce = 1'b1;
      err_count = 0;
      n_checks = 0;
      cnt3 = 0;
      cnt4 = 0;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      t_layout();
      t_lock();
      for (int d = 0; d < 4; d++) t_cap(1'b0, 2'b01, d[1:0], 1'b0, 8 >> d, 0);
      t_cap(1'b0, 2'b10, 2'b00, 1'b1, 8, 0);
      t_cap(1'b1, 2'b01, 2'b10, 1'b1, 0, 2);
      t_cap(1'b1, 2'b10, 2'b00, 1'b0, 0, 8);
      t_src(16'h0011, 1'b0, 1, 0, 0);
      t_src(16'h0011, 1'b0, 2, 4, 0);
      t_src(16'h0303, 1'b0, 2, 0, 0);
      t_src(16'h0303, 1'b1, 2, 4, 4);
      t_ref(16'h0000, 1'b0);
      t_ref(16'h0004, 1'b1);
      t_ref(16'h0080, 1'b0);
      @(posedge sys_clk);
      ext <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk({31'h0, ref3}, 32'h0);
      end_of_test();
   end
endmodule

bind ccmode_ch3_ch4_config ccmode_assertions u_chk (.sys_clk(sys_clk),
   .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .filtered_external_trigger(filtered_external_trigger),
   .ch3_raw_reference(ch3_raw_reference),
   .ch3_output_reference(ch3_output_reference),
   .ch3_capture_event(ch3_capture_event), .ch3_out_cfg(ch3_out_cfg),
   .ch4_out_cfg(ch4_out_cfg), .ch3_is_input(ch3_is_input),
   .ch4_is_input(ch4_is_input));
